// ### rtl/sfdp16_pkg.sv
// Package: constants and carrier types for the parameter dword 16 and reset / status policy block
package sfdp16_pkg;
   // Parameter table window
   localparam logic [7:0] DW16_BASE = 8'h6C;
   localparam logic [7:0] DW16_B0 = 8'hE8;
   localparam logic [7:0] DW16_B1 = 8'h30;
   localparam logic [7:0] DW16_B2 = 8'hC0;
   localparam logic [7:0] DW16_B3 = 8'h80;
   // Field positions inside the dword
   localparam int ENTER4_MSB = 31;
   localparam int ENTER4_LSB = 24;
   localparam int EXIT4_MSB = 23;
   localparam int EXIT4_LSB = 14;
   localparam int SRST_MSB = 13;
   localparam int SRST_LSB = 8;
   localparam int RFU_BIT = 7;
   localparam int SRW_MSB = 6;
   localparam int SRW_LSB = 0;
   localparam logic [7:0] ENTER4_NONE = 8'h80;
   localparam logic [9:0] EXIT4_NONE = 10'h300;
   localparam logic [5:0] SRST_SEQ = 6'h30;
   localparam logic [6:0] SRW_METHOD = 7'h68;
   // Command codes
   localparam logic [7:0] CMD_RST_EN = 8'h66;
   localparam logic [7:0] CMD_RST = 8'h99;
   localparam logic [7:0] CMD_WREN = 8'h06;
   localparam logic [7:0] CMD_VWREN = 8'h50;
   localparam logic [7:0] CMD_WRSR = 8'h01;
   localparam logic [7:0] CMD_RDSFDP = 8'h5A;
   localparam logic [7:0] CMD_RDSR = 8'h05;
   localparam logic [7:0] SR1_RESET = 8'h00;
   // Timing
   localparam int CLK_MHZ = 10;
   localparam int RST_TIME_NS = 10000;
   localparam int RST_CYCLES = (RST_TIME_NS * CLK_MHZ) / 1000;
   // Bus widths: 1, 2 or 4 data lines
   typedef enum logic [1:0] {
      WID_1 = 2'b00,
      WID_2 = 2'b01,
      WID_4 = 2'b10
   } width_t;
   // Serial pins as seen by the block
   typedef struct packed {
      logic cs_b;
      logic sck;
      logic [3:0] io;
   } pins_t;
   // Decoded byte from the deserialiser
   typedef struct packed {
      logic first;
      logic [7:0] data;
   } rx_byte_t;
endpackage : sfdp16_pkg

// ### rtl/spi_byte_rx.sv
// Deserialiser: synchronises the serial pins and assembles bytes on 1, 2 or 4 lines
`timescale 1ns/10ps
module spi_byte_rx (
   input wire logic clk,
   input wire logic rst_b,
   input wire sfdp16_pkg::pins_t pins,
   input wire sfdp16_pkg::width_t width,
   output sfdp16_pkg::rx_byte_t rx,
   output logic rx_vld,
   output logic sel,
   output logic sck_fall,
   output logic frame_end
);
   import sfdp16_pkg::*;
   pins_t s1_r;
   pins_t s2_r;
   logic sck_d_r;
   logic cs_d_r;
   logic [7:0] sh_r;
   logic [3:0] cnt_r;
   logic first_r;
   logic [3:0] need;
   logic rise;
   // Two stages before any logic looks at the pins
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_r <= '{cs_b: 1'b1, sck: 1'b0, io: 4'h0};
         s2_r <= '{cs_b: 1'b1, sck: 1'b0, io: 4'h0};
         sck_d_r <= 1'b0;
         cs_d_r <= 1'b1;
      end else begin
         s1_r <= pins;
         s2_r <= s1_r;
         sck_d_r <= s2_r.sck;
         cs_d_r <= s2_r.cs_b;
      end
   end
   assign rise = s2_r.sck & ~sck_d_r & ~s2_r.cs_b;
   assign sck_fall = ~s2_r.sck & sck_d_r & ~s2_r.cs_b;
   assign sel = ~s2_r.cs_b;
   assign frame_end = s2_r.cs_b & ~cs_d_r;
   // Edges per byte depends on how many lines carry data
   always_comb begin
      case (width)
         WID_2: need = 4'd4;
         WID_4: need = 4'd2;
         default: need = 4'd8;
      endcase
   end
   // Shift on rising edges, restart at every deselect
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sh_r <= 8'h00;
         cnt_r <= 4'd0;
         first_r <= 1'b1;
         rx <= '0;
         rx_vld <= 1'b0;
      end else begin
         rx_vld <= 1'b0;
         if (s2_r.cs_b) begin
            cnt_r <= 4'd0;
            first_r <= 1'b1;
         end else if (rise) begin
            case (width)
               WID_2: sh_r <= {sh_r[5:0], s2_r.io[1:0]};
               WID_4: sh_r <= {sh_r[3:0], s2_r.io};
               default: sh_r <= {sh_r[6:0], s2_r.io[0]};
            endcase
            if (cnt_r == need - 4'd1) begin
               cnt_r <= 4'd0;
               rx_vld <= 1'b1;
               rx.first <= first_r;
               first_r <= 1'b0;
               case (width)
                  WID_2: rx.data <= {sh_r[5:0], s2_r.io[1:0]};
                  WID_4: rx.data <= {sh_r[3:0], s2_r.io};
                  default: rx.data <= {sh_r[6:0], s2_r.io[0]};
               endcase
            end else begin
               cnt_r <= cnt_r + 4'd1;
            end
         end
      end
   end
endmodule : spi_byte_rx

// ### rtl/sfdp16_ctrl.sv
// Command decode for parameter dword 16, two-step software reset and status register 1 write paths
// Summary of operation
// - Parameter reads at 6Ch..6Fh return E8h, 30h, C0h, 80h.
// - Enter 4-byte field, bits 31:24, reads 10000000b: unsupported.
// - Exit 4-byte field, bits 23:14, reads 11_0000_0000b: unsupported.
// - Reset happens only after 66h followed by 99h.
// - Reset commands decode on one, two or four lines per mode.
// - Status 1 powers up from non-volatile copy; its non-volatile write needs 06h.
// - Command 50h enables a volatile status 1 write that overrides.
// - Bit 7 reads one; bits 6:0 read 1101000b.
// - Any command other than 66h between 66h and 99h cancels the reset request.
// - Reset takes about 10us; no command accepted meanwhile.
`timescale 1ns/10ps
module sfdp16_ctrl #(
   parameter int RST_WAIT = sfdp16_pkg::RST_CYCLES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire sfdp16_pkg::pins_t pins,
   input wire sfdp16_pkg::width_t width,
   input wire logic [7:0] sr1_nv_init,
   output logic [3:0] io_out,
   output logic [3:0] io_oe,
   output logic [7:0] sr1_r,
   output logic [7:0] sr1_nv_r,
   output logic busy_r,
   output logic sw_reset_r
);
   import sfdp16_pkg::*;
   // Dword assembled from its fields, so each field is visible
   localparam logic [31:0] DW16 = {ENTER4_NONE, EXIT4_NONE, SRST_SEQ, 1'b1, SRW_METHOD};
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_DUMMY = 3'b010,
      ST_OUT = 3'b011,
      ST_WRSR = 3'b100,
      ST_SKIP = 3'b101
   } state_t;
   rx_byte_t rx;
   logic rx_vld;
   logic sel;
   logic sck_fall;
   logic frame_end;
   state_t st_r;
   logic [1:0] acnt_r;
   logic [7:0] addr_r;
   logic [7:0] oaddr_r;
   logic [7:0] obyte_r;
   logic [3:0] ocnt_r;
   logic [7:0] cmd_r;
   logic rst_arm_r;
   logic wren_r;
   logic vwren_r;
   logic vact_r;
   logic [7:0] sr1_v_r;
   logic [15:0] wait_r;
   logic start_rst;
   logic cmd_take;
   logic loaded_r;
   spi_byte_rx u_rx (
      .clk(clk),
      .rst_b(rst_b),
      .pins(pins),
      .width(width),
      .rx(rx),
      .rx_vld(rx_vld),
      .sel(sel),
      .sck_fall(sck_fall),
      .frame_end(frame_end)
   );
   // Opcode bytes are only taken while not busy with reset
   assign cmd_take = rx_vld & rx.first & ~busy_r;
   assign start_rst = frame_end & rst_arm_r & (cmd_r == CMD_RST);
   // Parameter byte lookup, outside the window reads as erased
   function automatic logic [7:0] param_byte(input logic [7:0] a);
      case (a)
         DW16_BASE: param_byte = DW16[7:0];
         DW16_BASE + 8'd1: param_byte = DW16[15:8];
         DW16_BASE + 8'd2: param_byte = DW16[23:16];
         DW16_BASE + 8'd3: param_byte = DW16[31:24];
         default: param_byte = 8'hFF;
      endcase
   endfunction : param_byte
   // ==========================================
   // Command sequencer
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= ST_IDLE;
         acnt_r <= 2'd0;
         addr_r <= 8'h00;
         cmd_r <= 8'h00;
      end else if (!sel || busy_r) begin
         st_r <= ST_IDLE;
         acnt_r <= 2'd0;
      end else if (rx_vld) begin
         case (st_r)
            ST_IDLE: begin
               if (cmd_take) begin
                  cmd_r <= rx.data;
                  if (rx.data == CMD_RDSFDP) begin
                     st_r <= ST_ADDR;
                  end else if (rx.data == CMD_WRSR) begin
                     st_r <= ST_WRSR;
                  end else begin
                     st_r <= ST_SKIP;
                  end
               end
            end
            ST_ADDR: begin
               acnt_r <= acnt_r + 2'd1;
               if (acnt_r == 2'd2) begin
                  addr_r <= rx.data;
                  st_r <= ST_DUMMY;
               end
            end
            ST_DUMMY: st_r <= ST_OUT;
            default: st_r <= st_r;
         endcase
      end
   end
   // ==========================================
   // Serial output of the parameter bytes on IO1, changed on falling edges
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         io_out <= 4'h0;
         io_oe <= 4'h0;
         obyte_r <= 8'h00;
         ocnt_r <= 4'd0;
         oaddr_r <= 8'h00;
      end else if (st_r != ST_OUT || !sel) begin
         // Own copy of the address so the sequencer stays its only writer
         io_oe <= 4'h0;
         ocnt_r <= 4'd0;
         oaddr_r <= addr_r;
         obyte_r <= param_byte(addr_r);
      end else if (sck_fall) begin
         io_oe <= 4'b0010;
         io_out <= {2'b00, obyte_r[7], 1'b0};
         if (ocnt_r == 4'd7) begin
            ocnt_r <= 4'd0;
            oaddr_r <= oaddr_r + 8'd1;
            obyte_r <= param_byte(oaddr_r + 8'd1);
         end else begin
            ocnt_r <= ocnt_r + 4'd1;
            obyte_r <= {obyte_r[6:0], 1'b0};
         end
      end
   end
   // ==========================================
   // Reset arming: only a 66h frame directly before 99h arms it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_arm_r <= 1'b0;
      end else if (busy_r) begin
         rst_arm_r <= 1'b0;
      end else if (cmd_take) begin
         if (rx.data == CMD_RST_EN) begin
            rst_arm_r <= 1'b1;
         end else if (rx.data != CMD_RST) begin
            rst_arm_r <= 1'b0;
         end
      end else if (frame_end && cmd_r == CMD_RST) begin
         rst_arm_r <= 1'b0;
      end
   end
   // Reset period counter; the count is a parameter so sims can shorten it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_r <= 1'b0;
         sw_reset_r <= 1'b0;
         wait_r <= 16'd0;
      end else if (start_rst) begin
         busy_r <= 1'b1;
         sw_reset_r <= 1'b1;
         wait_r <= 16'(RST_WAIT - 1);
      end else if (busy_r) begin
         sw_reset_r <= 1'b0;
         if (wait_r == 16'd0) begin
            busy_r <= 1'b0;
         end else begin
            wait_r <= wait_r - 16'd1;
         end
      end
   end
   // ==========================================
   // Status register 1: non-volatile copy loaded after reset release
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wren_r <= 1'b0;
         vwren_r <= 1'b0;
         vact_r <= 1'b0;
         sr1_nv_r <= SR1_RESET;
         sr1_v_r <= SR1_RESET;
         sr1_r <= SR1_RESET;
      end else if (!loaded_r) begin
         // Power-up: the non-volatile copy and sr1_r take the stored non-volatile value; sr1_v_r keeps SR1_RESET
         sr1_nv_r <= sr1_nv_init;
         sr1_r <= sr1_nv_init;
      end else if (sw_reset_r) begin
         wren_r <= 1'b0;
         vwren_r <= 1'b0;
         vact_r <= 1'b0;
         sr1_r <= sr1_nv_r;
      end else begin
         if (cmd_take && rx.data == CMD_WREN) begin
            wren_r <= 1'b1;
         end
         if (cmd_take && rx.data == CMD_VWREN) begin
            vwren_r <= 1'b1;
         end
         if (st_r == ST_WRSR && rx_vld) begin
            if (vwren_r) begin
               sr1_v_r <= rx.data;
               vact_r <= 1'b1;
               vwren_r <= 1'b0;
            end else if (wren_r) begin
               sr1_nv_r <= rx.data;
               wren_r <= 1'b0;
            end
         end
         sr1_r <= vact_r ? sr1_v_r : sr1_nv_r;
      end
   end
   // Strap sampled once per power-up at the first clock after release
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         loaded_r <= 1'b0;
      end else begin
         loaded_r <= 1'b1;
      end
   end
   // ==========================================
   // Checks
   property p_reset_pair;
      @(posedge clk) disable iff (!rst_b)
      start_rst |-> ##1 busy_r && sw_reset_r;
   endproperty
   a_reset_pair: assert property (p_reset_pair) else $error("reset pair not honoured");
   property p_no_lone_reset;
      @(posedge clk) disable iff (!rst_b)
      (frame_end && !rst_arm_r) |=> !sw_reset_r;
   endproperty
   a_no_lone_reset: assert property (p_no_lone_reset) else $error("lone reset acted");
   property p_busy_block;
      @(posedge clk) disable iff (!rst_b)
      (busy_r && rx_vld && rx.first) |=> st_r == ST_IDLE && !wren_r && !vwren_r && !rst_arm_r;
   endproperty
   a_busy_block: assert property (p_busy_block) else $error("command taken while resetting");
   property p_cancel;
      @(posedge clk) disable iff (!rst_b)
      (cmd_take && rx.data != CMD_RST_EN && rx.data != CMD_RST) |=> !rst_arm_r;
   endproperty
   a_cancel: assert property (p_cancel) else $error("reset arm not cancelled");
   property p_dword;
      @(posedge clk) disable iff (!rst_b)
      (st_r == ST_OUT && sel && sck_fall && ocnt_r == 4'd7 && oaddr_r == DW16_BASE - 8'd1) |=> obyte_r == 8'hE8;
   endproperty
   a_dword: assert property (p_dword) else $error("parameter bytes wrong");
   property p_fields;
      @(posedge clk) disable iff (!rst_b)
      (st_r == ST_OUT && sel && sck_fall && ocnt_r == 4'd7 && oaddr_r == DW16_BASE + 8'd2) |=> obyte_r == 8'h80;
   endproperty
   a_fields: assert property (p_fields) else $error("dword fields wrong");
   property p_nv_wren;
      @(posedge clk) disable iff (!rst_b)
      (loaded_r && !wren_r && !sw_reset_r) |=> sr1_nv_r == $past(sr1_nv_r);
   endproperty
   a_nv_wren: assert property (p_nv_wren) else $error("nv write without enable");
   property p_vol_override;
      @(posedge clk) disable iff (!rst_b)
      (vact_r && !sw_reset_r) |=> sr1_r == $past(sr1_v_r);
   endproperty
   a_vol_override: assert property (p_vol_override) else $error("volatile copy not in use");
   property p_busy_len;
      @(posedge clk) disable iff (!rst_b)
      $rose(busy_r) |-> busy_r [*8];
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("reset period too short");
endmodule : sfdp16_ctrl

// ### test/spi_host_model.sv
// Host controller model: drives serial frames on the flash pins and resolves the shared data lines
`timescale 1ns/10ps
module spi_host_model (
   input wire logic clk,
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe,
   output sfdp16_pkg::pins_t pins
);
   import sfdp16_pkg::*;
   logic cs_b_r;
   logic sck_r;
   logic [3:0] hout_r;
   logic [3:0] hoe_r;
   logic [3:0] float_r = 4'h0;
   // =========================================================
   // Pin levels
   // Undriven lines follow a count that steps by 5 each cycle; read every 8 cycles, line 1 keeps one level
   assign pins = '{cs_b: cs_b_r, sck: sck_r,
                   io: (io_oe & io_out) | (~io_oe & hoe_r & hout_r) | (~io_oe & ~hoe_r & float_r)};
   initial begin
      cs_b_r = 1'b1;
      sck_r = 1'b0;
      hout_r = 4'h0;
      hoe_r = 4'h0;
   end
   // Pattern for released lines
   always @(posedge clk) float_r <= float_r + 4'h5;
   // =========================================================
   // Frame tasks
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_clk
   // One link clock period of 8 system clocks; the level is sampled just before the rise
   task automatic edge_out(input logic [3:0] val, input logic [3:0] oe, output logic rd);
      hout_r = val;
      hoe_r = oe;
      wait_clk(4);
      rd = pins.io[1];
      sck_r = 1'b1;
      wait_clk(4);
      sck_r = 1'b0;
   endtask : edge_out
   // Byte MSB first on 1, 2 or 4 lines; when reading only line 0 is driven
   task automatic xfer_byte(input logic [7:0] tx, input width_t w, input logic rd_en, output logic [7:0] rx);
      int nb;
      logic b;
      logic [3:0] m;
      nb = (w == WID_4) ? 4 : (w == WID_2) ? 2 : 1;
      m = (w == WID_4) ? 4'hF : (w == WID_2) ? 4'h3 : 4'h1;
      rx = 8'h00;
      for (int k = 8 - nb; k >= 0; k -= nb) begin
         edge_out(4'(tx >> k) & m, rd_en ? 4'h1 : m, b);
         rx = {rx[6:0], b};
      end
   endtask : xfer_byte
   task automatic start_frame();
      wait_clk(2);
      cs_b_r = 1'b0;
      wait_clk(4);
   endtask : start_frame
   // Returns soon after deselect so the caller can still see a one-cycle reset pulse
   task automatic end_frame();
      hoe_r = 4'h0;
      wait_clk(4);
      cs_b_r = 1'b1;
      wait_clk(2);
   endtask : end_frame
   task automatic send(input logic [7:0] op, input width_t w, input int n, input logic [7:0] dat);
      logic [7:0] rx;
      start_frame();
      xfer_byte(op, w, 1'b0, rx);
      if (n > 0) xfer_byte(dat, w, 1'b0, rx);
      end_frame();
   endtask : send
   // Parameter read on one line: opcode, three address bytes, dummy, six data bytes
   task automatic read_param(input logic [7:0] addr, output logic [47:0] dat);
      logic [7:0] rx;
      start_frame();
      xfer_byte(CMD_RDSFDP, WID_1, 1'b0, rx);
      xfer_byte(8'h00, WID_1, 1'b0, rx);
      xfer_byte(8'h00, WID_1, 1'b0, rx);
      xfer_byte(addr, WID_1, 1'b0, rx);
      xfer_byte(8'h00, WID_1, 1'b0, rx);
      dat = 48'h0;
      for (int i = 0; i < 6; i++) begin
         xfer_byte(8'h00, WID_1, 1'b1, rx);
         dat = {dat[39:0], rx};
      end
      end_frame();
   endtask : read_param
   // All ones on four lines for eight clocks leaves continuous quad read before a reset
   task automatic exit_qread();
      logic b;
      start_frame();
      repeat (8) edge_out(4'hF, 4'hF, b);
      end_frame();
   endtask : exit_qread
endmodule : spi_host_model

// ### test/sfdp_dword16_reset_sr_policy_tb.sv
// Testbench: parameter dword 16 readout, two-step software reset and status register 1 write paths
`timescale 1ns/10ps
module sfdp_dword16_reset_sr_policy_tb;
   import sfdp16_pkg::*;
   // Ten microseconds at 10 MHz; a one-line frame fits inside it
   localparam int RST_WAIT = 100;
   logic clk;
   logic rst_b;
   width_t width;
   pins_t pins;
   logic [3:0] io_out;
   logic [3:0] io_oe;
   logic [7:0] sr1_r;
   logic [7:0] sr1_nv_r;
   logic busy_r;
   logic sw_reset_r;
   logic [7:0] nv_init;
   int miscompares;
   int n_tests;
   int cyc;
   // =========================================================
   // Instances
   sfdp16_ctrl #(.RST_WAIT(RST_WAIT)) u_dut (.clk(clk), .rst_b(rst_b), .pins(pins), .width(width),
      .sr1_nv_init(nv_init), .io_out(io_out), .io_oe(io_oe), .sr1_r(sr1_r), .sr1_nv_r(sr1_nv_r),
      .busy_r(busy_r), .sw_reset_r(sw_reset_r));
   spi_host_model u_host (.clk(clk), .io_out(io_out), .io_oe(io_oe), .pins(pins));
   // =========================================================
   // Clock and hang guard
   always #50 clk = ~clk;
   // Whole run needs well under 10000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         end_sim();
      end
   end
   // =========================================================
   // Shared tasks
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim
   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic settle();
      repeat (8) @(posedge clk);
      #1;
   endtask : settle
   // Looks for the reset pulse for 20 cycles, stopping at the cycle where it stands
   task automatic see_pulse(output logic hit);
      int i;
      i = 0;
      while (sw_reset_r !== 1'b1 && i < 20) begin
         @(posedge clk);
         #1;
         i++;
      end
      hit = (sw_reset_r === 1'b1);
   endtask : see_pulse
   // =========================================================
   // Scenarios
   task automatic t_status();
      check({sr1_nv_r, sr1_r}, 16'h1C1C);
      u_host.send(8'h01, WID_1, 1, 8'h3C);
      settle();
      check({sr1_nv_r, sr1_r}, 16'h1C1C);
      u_host.send(8'h06, WID_1, 0, 8'h00);
      u_host.send(8'h01, WID_1, 1, 8'h3C);
      settle();
      check({sr1_nv_r, sr1_r}, 16'h3C3C);
      u_host.send(8'h50, WID_1, 0, 8'h00);
      u_host.send(8'h01, WID_1, 1, 8'hA4);
      settle();
      check({sr1_nv_r, sr1_r}, 16'h3CA4);
   endtask : t_status
   // Starts one byte early and runs one past the dword to see both neighbours
   task automatic t_param();
      logic [47:0] d;
      logic [31:0] dw;
      u_host.read_param(8'h6B, d);
      check(d, 48'hFFE830C080FF);
      dw = {d[15:8], d[23:16], d[31:24], d[39:32]};
      check(dw[31:24], 8'h80);
      check(dw[23:14], 10'h300);
      check({dw[7], dw[6:0]}, 8'hE8);
   endtask : t_param
   // Reset in the given width, with a command sent while the reset period runs
   task automatic t_reset(input width_t w);
      logic hit;
      int n;
      width = w;
      u_host.send(8'h50, w, 0, 8'h00);
      u_host.send(8'h01, w, 1, 8'hA4);
      settle();
      check(sr1_r, 8'hA4);
      u_host.exit_qread();
      u_host.send(8'h66, w, 0, 8'h00);
      u_host.send(8'h99, w, 0, 8'h00);
      see_pulse(hit);
      check(hit, 1'b1);
      n = 0;
      fork
         for (int i = 0; i < 300; i++) begin
            if (busy_r === 1'b1) n++;
            @(posedge clk);
            #1;
         end
         u_host.send(8'h50, w, 0, 8'h00);
      join
      check(n, RST_WAIT);
      check({sr1_nv_r, sr1_r}, 16'h3C3C);
      u_host.send(8'h01, w, 1, 8'h5A);
      settle();
      check(sr1_r, 8'h3C);
   endtask : t_reset
   task automatic t_broken();
      logic hit;
      width = WID_1;
      u_host.send(8'h66, WID_1, 0, 8'h00);
      u_host.send(8'h05, WID_1, 0, 8'h00);
      u_host.send(8'h99, WID_1, 0, 8'h00);
      see_pulse(hit);
      check({hit, busy_r}, 2'b00);
      u_host.send(8'h50, WID_1, 0, 8'h00);
      u_host.send(8'h01, WID_1, 1, 8'hC8);
      u_host.send(8'h99, WID_1, 0, 8'h00);
      see_pulse(hit);
      check({hit, busy_r, sr1_r}, 10'h0C8);
   endtask : t_broken
   // =========================================================
   // Main sequence
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      // Stored non-volatile status value seen at power-up
      nv_init = 8'h1C;
      width = WID_1;
      miscompares = 0;
      n_tests = 0;
      cyc = 0;
      repeat (6) @(posedge clk);
      #1;
      rst_b = 1'b1;
      settle();
      t_status();
      t_param();
      t_reset(WID_1);
      t_reset(WID_2);
      t_reset(WID_4);
      t_broken();
      end_sim();
   end
endmodule : sfdp_dword16_reset_sr_policy_tb
